//--- tcu_capture_compare.sv
// Purpose: Timer capture/compare unit with capture buffer and compare file
// Assumes: Register port master per bus rules; pins asynchronous to clk
// Notes:   Capture line 2/3 pins double as output lines 4/5
//
// Our own choice: strobed register access.

`timescale 1ns/1ns

module tcu_capture_compare
	import tcu_pkg::*;
#(
	parameter int FIFO_DEPTH = 7,
	parameter int FILE_DEPTH = 8
)
(
	input  wire logic            clk,
	input  wire logic            resetn,
	input  wire tcu_bus_req_type bus,
	output logic [15:0]          rd_data,
	input  wire logic [3:0]      capture_line_pin,
	input  wire logic            t2_clock_pin,
	output logic [5:0]           output_line,
	output logic [1:0]           output_line_oe,
	output logic                 capture_irq,
	output logic                 swtimer_irq,
	output logic                 conv_start
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// Status thresholds and the 3-bit sweep counter fix both depths
	if (FIFO_DEPTH != 7)
		$error("FIFO_DEPTH must be 7");
	if (FILE_DEPTH != 8)
		$error("FILE_DEPTH must be 8");

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0]                  sync1;
		logic [4:0]                  sync2;
		logic [4:0]                  prev;
		logic [2:0]                  slot;
		logic [15:0]                 t1;
		logic [15:0]                 t2;
		logic                        t2_pend;
		logic [7:0]                  io_control_first;
		logic [7:0]                  mode;
		logic [7:0]                  io_control_second;
		logic [5:0]                  flags;
		logic [3:0][2:0]             pcnt;
		logic [FIFO_DEPTH-1:0][19:0] fifo;
		logic [2:0]                  wp;
		logic [2:0]                  rp;
		logic [3:0]                  cnt;
		logic                        lvl;
		logic                        hold_v;
		logic [19:0]                 hold;
		logic [6:0]                  tag;
		logic                        ch_v;
		logic [15:0]                 ch_time;
		logic [6:0]                  ch_tag;
		logic [FILE_DEPTH-1:0]       fv;
		logic [FILE_DEPTH-1:0][15:0] ft;
		logic [FILE_DEPTH-1:0][6:0]  ftag;
		logic [5:0]                  pv;
		logic [5:0]                  pval;
		logic [3:0]                  pflag;
		logic                        pirq;
		logic                        pconv;
		logic                        pt2rst;
		logic [5:0]                  outs;
		logic                        cap_irq;
		logic                        swt_irq;
		logic                        conv;
		logic [15:0]                 rdata;
	} tcu_state_type;

	tcu_state_type s;
	tcu_state_type next_s;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic       tick;
		logic       ev;
		logic       move;
		logic       push;
		logic       rise;
		logic       fall;
		logic       level;
		logic [3:0] hit;
		logic [3:0] chan;
		logic [6:0] etag;
		logic [15:0] ref_time;
		tick = 1'b0;
		ev = 1'b0;
		move = 1'b0;
		push = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		level = 1'b0;
		hit = 4'h0;
		chan = 4'h0;
		etag = 7'h00;
		ref_time = 16'h0000;
		next_s = s;
		next_s.cap_irq = 1'b0;
		next_s.swt_irq = 1'b0;
		next_s.conv = 1'b0;
		next_s.rdata = 16'h0000;

		// Pins pass two flops; edges are taken from the second stage only
		next_s.sync1 = {t2_clock_pin, capture_line_pin};
		next_s.sync2 = s.sync1;
		next_s.prev = s.sync2;
		next_s.slot = s.slot + 3'h1;
		tick = (s.slot == TCU_SWEEP_LAST);

		// ------------------------------------------------------------
		// Register reads and their side effects
		// ------------------------------------------------------------
		if (bus.rd)
		begin
			unique case (bus.addr)
				TCU_OFS_TIME:
				begin
					// An empty holding register reads stale time and pops nothing
					next_s.rdata = s.hold[15:0];
					next_s.hold_v = 1'b0;
				end
				TCU_OFS_STAT:
					next_s.rdata = {8'h00, s.sync2[3:0], s.hold[19:16]};
				TCU_OFS_IO_CONTROL_FIRST:
					next_s.rdata = {8'h00, s.io_control_first};
				TCU_OFS_MODE:
					next_s.rdata = {8'h00, s.mode};
				TCU_OFS_IO_CONTROL_SECOND:
					next_s.rdata = {8'h00, s.io_control_second};
				TCU_OFS_IO_STATUS_FIRST:
				begin
					next_s.rdata = {8'h00, 2'h0, s.outs};
					next_s.rdata[TCU_IO_STATUS_FIRST_BUSY] = s.ch_v;
					next_s.rdata[TCU_IO_STATUS_FIRST_FULL] = s.ch_v | (&s.fv);
				end
				TCU_OFS_IO_STATUS_SECOND:
				begin
					next_s.rdata = {8'h00, 2'h0, s.flags};
					next_s.rdata[TCU_IO_STATUS_SECOND_NONEMPTY] = (s.cnt != 4'h0);
					next_s.rdata[TCU_IO_STATUS_SECOND_FULL] = (s.cnt >= TCU_FULL_MARK);
					// Flags raised in this same cycle are set again below, so set wins
					next_s.flags = 6'h00;
				end
				default:
					next_s.rdata = 16'h0000;
			endcase
		end

		// ------------------------------------------------------------
		// Timers
		// ------------------------------------------------------------
		if (tick)
		begin
			next_s.t1 = s.t1 + 16'h0001;
			if (s.t1 == TCU_TIMER_MAX)
				next_s.flags[TCU_IO_STATUS_SECOND_T1_OVF] = 1'b1;
		end
		// Edges are held until the next sweep end so no count is lost
		// Two edges inside one sweep merge into a single count
		if (s.sync2[4] != s.prev[4])
			next_s.t2_pend = 1'b1;
		else if (tick)
			next_s.t2_pend = 1'b0;
		if (tick && s.t2_pend)
		begin
			next_s.t2 = s.t2 + 16'h0001;
			if (s.t2 == TCU_TIMER_MAX)
				next_s.flags[TCU_IO_STATUS_SECOND_T2_OVF] = 1'b1;
		end

		// ------------------------------------------------------------
		// Capture detection
		// ------------------------------------------------------------
		for (int i = 0; i < 4; i++)
		begin
			rise = s.sync2[i] & ~s.prev[i];
			fall = ~s.sync2[i] & s.prev[i];
			if (s.io_control_first[i])
			begin
				// The eighth-edge counter keeps its phase across mode changes
				unique case (s.mode[2*i +: 2])
					TCU_MODE_EIGHTH:
					begin
						if (rise)
						begin
							next_s.pcnt[i] = s.pcnt[i] + 3'h1;
							hit[i] = (s.pcnt[i] == TCU_EIGHTH_LAST);
						end
					end
					TCU_MODE_RISE:
						hit[i] = rise;
					TCU_MODE_FALL:
						hit[i] = fall;
					TCU_MODE_BOTH:
						hit[i] = rise | fall;
				endcase
			end
		end
		// Simultaneous events on several lines share one record
		ev = |hit;

		// ------------------------------------------------------------
		// Capture buffer and holding register
		// ------------------------------------------------------------
		move = !s.hold_v && (s.cnt != 4'h0);
		push = ev && ((s.cnt < TCU_FULL_MARK) || move);
		if (move)
		begin
			next_s.hold = s.fifo[s.rp];
			next_s.hold_v = 1'b1;
			next_s.rp = (s.rp == 3'(FIFO_DEPTH - 1)) ? 3'h0 : s.rp + 3'h1;
		end
		if (push)
		begin
			next_s.fifo[s.wp] = {s.sync2[3:0], s.t1};
			next_s.wp = (s.wp == 3'(FIFO_DEPTH - 1)) ? 3'h0 : s.wp + 3'h1;
		end
		next_s.cnt = s.cnt + {3'h0, push} - {3'h0, move};
		level = (next_s.cnt >= TCU_LEVEL_MARK);
		next_s.lvl = level;
		// Level mode pulses only on the crossing to six; dropping below six re-arms it
		if (s.io_control_second[TCU_IO_CONTROL_SECOND_IRQ_SEL])
			next_s.cap_irq = level && !s.lvl;
		else
			next_s.cap_irq = move;

		// ------------------------------------------------------------
		// Compare sweep
		// ------------------------------------------------------------
		etag = s.ftag[s.slot];
		ref_time = etag[TCU_TAG_T2] ? s.t2 : s.t1;
		chan = etag[3:0];
		if (s.fv[s.slot] && (s.ft[s.slot] == ref_time))
		begin
			next_s.fv[s.slot] = 1'b0;
			if (chan < TCU_CH_LINES)
			begin
				// Last match in a sweep wins, so an opposite action cancels
				next_s.pv[chan[2:0]] = 1'b1;
				next_s.pval[chan[2:0]] = etag[TCU_TAG_SET];
			end
			else if (chan[3:2] == TCU_CH_SWT)
			begin
				next_s.pflag[chan[1:0]] = 1'b1;
				next_s.pirq = 1'b1;
			end
			else if (chan == TCU_CH_T2RST)
			begin
				next_s.pt2rst = 1'b1;
				next_s.pirq = next_s.pirq | etag[TCU_TAG_IRQ];
			end
			else if (chan == TCU_CH_CONV)
			begin
				next_s.pconv = 1'b1;
				next_s.pirq = next_s.pirq | etag[TCU_TAG_IRQ];
			end
			else
				next_s.pirq = next_s.pirq | etag[TCU_TAG_IRQ];
		end
		// The comparator never looks at the holding register
		if (s.ch_v && !next_s.fv[s.slot])
		begin
			next_s.fv[s.slot] = 1'b1;
			next_s.ft[s.slot] = s.ch_time;
			next_s.ftag[s.slot] = s.ch_tag;
			next_s.ch_v = 1'b0;
		end

		// ------------------------------------------------------------
		// Register writes
		// ------------------------------------------------------------
		if (bus.wr)
		begin
			unique case (bus.addr)
				TCU_OFS_TIME:
				begin
					next_s.ch_v = 1'b1;
					next_s.ch_time = bus.wdata;
					next_s.ch_tag = s.tag;
				end
				TCU_OFS_STAT:
					next_s.tag = bus.wdata[6:0];
				TCU_OFS_IO_CONTROL_FIRST:
					next_s.io_control_first = bus.wdata[7:0];
				TCU_OFS_MODE:
					next_s.mode = bus.wdata[7:0];
				TCU_OFS_IO_CONTROL_SECOND:
					next_s.io_control_second = bus.wdata[7:0];
				default:
					next_s.io_control_first = s.io_control_first;
			endcase
		end

		// ------------------------------------------------------------
		// Apply collected actions at the end of each sweep
		// ------------------------------------------------------------
		if (tick)
		begin
			// Outputs move only at sweep ends, at most one change per eight cycles
			for (int k = 0; k < 6; k++)
			begin
				if (next_s.pv[k])
					next_s.outs[k] = next_s.pval[k];
			end
			next_s.flags[3:0] = next_s.flags[3:0] | next_s.pflag;
			next_s.swt_irq = next_s.pirq;
			next_s.conv = next_s.pconv;
			// Reset wins over a same-sweep count; stale entries stay put
			if (next_s.pt2rst)
				next_s.t2 = 16'h0000;
			next_s.pv = 6'h00;
			next_s.pflag = 4'h0;
			next_s.pirq = 1'b0;
			next_s.pconv = 1'b0;
			next_s.pt2rst = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s <= '0;
		else
			s <= next_s;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rd_data = s.rdata;
	assign output_line = s.outs;
	assign output_line_oe = {s.io_control_second[TCU_IO_CONTROL_SECOND_OUT5_EN], s.io_control_second[TCU_IO_CONTROL_SECOND_OUT4_EN]};
	assign capture_irq = s.cap_irq;
	assign swtimer_irq = s.swt_irq;
	assign conv_start = s.conv;

endmodule // tcu_capture_compare

//--- tcu_capture_compare_asserts.sv
// Purpose: Port checker for the capture/compare unit
// Assumes: One clock domain, reset active low
// Notes:   Bound to every instance of the unit
`timescale 1ns/1ns

module tcu_cc_asserts
	import tcu_pkg::*;
(
	input wire logic            clk,
	input wire logic            resetn,
	input wire tcu_bus_req_type bus,
	input wire logic [15:0]     rd_data,
	input wire logic [5:0]      output_line,
	input wire logic [1:0]      output_line_oe,
	input wire logic            capture_irq,
	input wire logic            swtimer_irq,
	input wire logic            conv_start
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	logic [1:0] oe_want;

	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
			oe_want <= 2'h0;
		else if (bus.wr && bus.addr == TCU_OFS_IO_CONTROL_SECOND)
			oe_want <= {bus.wdata[TCU_IO_CONTROL_SECOND_OUT5_EN], bus.wdata[TCU_IO_CONTROL_SECOND_OUT4_EN]};

	// Actions land once per sweep of eight
	sequence s_conv_quiet; !conv_start [*7]; endsequence
	sequence s_swt_quiet; !swtimer_irq [*7]; endsequence
	sequence s_out_still; $stable(output_line) [*7]; endsequence

	chk_oe_follows: assert property ($stable(oe_want) |=> output_line_oe == oe_want)
		else $error("output enable differs from control");
	chk_conv_gap: assert property (conv_start |=> s_conv_quiet)
		else $error("conversion pulses closer than a sweep");
	chk_swt_gap: assert property (swtimer_irq |=> s_swt_quiet)
		else $error("timer pulses closer than a sweep");
	chk_out_sweep: assert property ($changed(output_line) |=> s_out_still)
		else $error("output lines changed inside a sweep");
	chk_reset_quiet: assert property ($rose(resetn) |-> output_line == 6'h00 && !conv_start)
		else $error("outputs active right after reset");
	chk_cirq_single: assert property (capture_irq |=> !capture_irq)
		else $error("capture interrupt longer than one cycle");
	chk_rd_only_after: assert property (rd_data != 16'h0000 |-> $past(bus.rd))
		else $error("read data without a read");
	chk_unmapped_zero: assert property (bus.rd && bus.addr == 8'h00 |=> rd_data == 16'h0000)
		else $error("unmapped read not zero");
endmodule // tcu_cc_asserts

bind tcu_capture_compare tcu_cc_asserts u_tcu_cc_asserts (.clk(clk), .resetn(resetn), .bus(bus),
	.rd_data(rd_data), .output_line(output_line), .output_line_oe(output_line_oe),
	.capture_irq(capture_irq), .swtimer_irq(swtimer_irq), .conv_start(conv_start));

//--- tcu_partner.sv
// Purpose: Event sources on the capture lines and timer-two pin
// Assumes: Driven from the bench by task calls, one at a time
// Notes:   Shared pins follow the unit while it drives them
`timescale 1ns/1ns

module tcu_partner
	import tcu_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [5:0] output_line,
	input  wire logic [1:0] output_line_oe,
	output logic [3:0]      capture_line_pin,
	output logic            t2_clock_pin
);
	logic [3:0] src;

	initial
	begin
		src = 4'h0;
		t2_clock_pin = 1'b0;
	end

	// Wire level of pins 2/3 resolved from both drivers
	assign capture_line_pin = {output_line_oe[1] ? output_line[5] : src[3],
		output_line_oe[0] ? output_line[4] : src[2], src[1:0]};

	// Gap of eight or more keeps the input speed limit
	task automatic toggle_line(input int i, input int gap);
		@(posedge clk);
		src[i] <= ~src[i];
		repeat (gap - 1) @(posedge clk);
	endtask

	task automatic toggle_t2(input int gap);
		@(posedge clk);
		t2_clock_pin <= ~t2_clock_pin;
		repeat (gap - 1) @(posedge clk);
	endtask
endmodule // tcu_partner

//--- tcu_pkg.sv
// Purpose: Shared constants and carriers of the timer capture/compare unit
// Assumes: One state time equals one clk cycle
// Notes:   Register offsets are byte addresses on the plain register port

package tcu_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] TCU_OFS_TIME = 8'h04;
	localparam logic [7:0] TCU_OFS_STAT = 8'h06;
	localparam logic [7:0] TCU_OFS_IO_CONTROL_FIRST = 8'h15;
	localparam logic [7:0] TCU_OFS_MODE = 8'h16;
	localparam logic [7:0] TCU_OFS_IO_CONTROL_SECOND = 8'h17;
	localparam logic [7:0] TCU_OFS_IO_STATUS_FIRST = 8'h18;
	localparam logic [7:0] TCU_OFS_IO_STATUS_SECOND = 8'h19;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TCU_IO_CONTROL_SECOND_IRQ_SEL = 7;
	localparam int TCU_IO_CONTROL_SECOND_OUT4_EN = 4;
	localparam int TCU_IO_CONTROL_SECOND_OUT5_EN = 6;
	localparam int TCU_IO_STATUS_SECOND_NONEMPTY = 7;
	localparam int TCU_IO_STATUS_SECOND_FULL = 6;
	localparam int TCU_IO_STATUS_SECOND_T2_OVF = 5;
	localparam int TCU_IO_STATUS_SECOND_T1_OVF = 4;
	localparam int TCU_IO_STATUS_FIRST_BUSY = 7;
	localparam int TCU_IO_STATUS_FIRST_FULL = 6;
	localparam int TCU_TAG_T2 = 6;
	localparam int TCU_TAG_SET = 5;
	localparam int TCU_TAG_IRQ = 4;

	// ----------------------------------------------------------------
	// Encodings and timing
	// ----------------------------------------------------------------
	localparam logic [1:0] TCU_MODE_EIGHTH = 2'h0;
	localparam logic [1:0] TCU_MODE_RISE = 2'h1;
	localparam logic [1:0] TCU_MODE_FALL = 2'h2;
	localparam logic [1:0] TCU_MODE_BOTH = 2'h3;
	localparam logic [3:0] TCU_CH_LINES = 4'h6;
	localparam logic [1:0] TCU_CH_SWT = 2'h2;
	localparam logic [3:0] TCU_CH_T2RST = 4'hE;
	localparam logic [3:0] TCU_CH_CONV = 4'hF;
	localparam logic [2:0] TCU_EIGHTH_LAST = 3'h7;
	localparam logic [2:0] TCU_SWEEP_LAST = 3'h7;
	localparam logic [3:0] TCU_LEVEL_MARK = 4'h6;
	localparam logic [3:0] TCU_FULL_MARK = 4'h7;
	localparam logic [15:0] TCU_TIMER_MAX = 16'hFFFF;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} tcu_bus_req_type;

endpackage

//--- tcu_tb.sv
// Purpose: Self-checking bench of the capture/compare unit
// Assumes: Register master per bus rules, 10 MHz clock
// Notes:   Event sources live in the partner model
`timescale 1ns/1ns

module tb
	import tcu_pkg::*;
;
	logic            clk;
	logic            resetn;
	tcu_bus_req_type bus;
	logic [15:0]     rd_data;
	logic [3:0]      cap_pin;
	logic            t2_pin;
	logic [5:0]      out_line;
	logic [1:0]      out_oe;
	logic            cap_irq;
	logic            swt_irq;
	logic            conv;
	int              num_errors = 0;
	int              checks_done = 0;
	int              cap_seen = 0;
	int              swt_seen = 0;
	int              conv_seen = 0;
	int              cycles = 0;

	tcu_capture_compare u_tcu_capture_compare (.clk(clk), .resetn(resetn), .bus(bus),
		.rd_data(rd_data), .capture_line_pin(cap_pin), .t2_clock_pin(t2_pin),
		.output_line(out_line), .output_line_oe(out_oe), .capture_irq(cap_irq),
		.swtimer_irq(swt_irq), .conv_start(conv));
	tcu_partner u_tcu_partner (.clk(clk), .output_line(out_line), .output_line_oe(out_oe),
		.capture_line_pin(cap_pin), .t2_clock_pin(t2_pin));

	always #50 clk = ~clk;

	// Pulses counted on the falling edge, clear of update races
	always @(negedge clk)
	begin
		cycles++;
		cap_seen += int'(cap_irq === 1'b1);
		swt_seen += int'(swt_irq === 1'b1);
		conv_seen += int'(conv === 1'b1);
		if (cycles == 5000)
		begin
			num_errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{1'b0, 1'b1, a, d};
		@(posedge clk);
		bus <= '0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		bus <= '{1'b1, 1'b0, a, 16'h0000};
		@(posedge clk);
		bus <= '0;
		@(negedge clk);
		d = rd_data;
	endtask

	task automatic rdchk(input string n, input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(n, d & m, e);
	endtask

	task automatic t_reset();
		rdchk("io_status_second", TCU_OFS_IO_STATUS_SECOND, 16'h00FF, 16'h0000);
		rdchk("io_status_first", TCU_OFS_IO_STATUS_FIRST, 16'h00C0, 16'h0000);
		rdchk("unmapped", 8'h00, 16'hFFFF, 16'h0000);
	endtask

	task automatic t_capture();
		int n;
		logic [15:0] a;
		logic [15:0] b;
		wr(TCU_OFS_IO_CONTROL_FIRST, 16'h0001);
		wr(TCU_OFS_MODE, 16'h0055);
		wr(TCU_OFS_IO_CONTROL_SECOND, 16'h0000);
		n = cap_seen;
		u_tcu_partner.toggle_line(1, 16);
		chk("masked", 16'(cap_seen - n), 16'h0000);
		repeat (3) u_tcu_partner.toggle_line(0, 16);
		repeat (12) @(posedge clk);
		chk("load1", 16'(cap_seen - n), 16'h0001);
		rdchk("nonempty", TCU_OFS_IO_STATUS_SECOND, 16'h00C0, 16'h0080);
		rdchk("pins", TCU_OFS_STAT, 16'h000F, 16'h0003);
		rd(TCU_OFS_TIME, a);
		repeat (4) @(posedge clk);
		chk("load2", 16'(cap_seen - n), 16'h0002);
		rd(TCU_OFS_TIME, b);
		chk("stamp", b - a, 16'h0004);
	endtask

	task automatic t_overflow();
		int n;
		logic [15:0] d;
		wr(TCU_OFS_IO_CONTROL_SECOND, 16'h0080);
		n = cap_seen;
		repeat (18) u_tcu_partner.toggle_line(0, 8);
		repeat (12) @(posedge clk);
		chk("level", 16'(cap_seen - n), 16'h0001);
		rdchk("full", TCU_OFS_IO_STATUS_SECOND, 16'h00C0, 16'h00C0);
		repeat (7) rd(TCU_OFS_TIME, d);
		rdchk("dropped", TCU_OFS_IO_STATUS_SECOND, 16'h0080, 16'h0000);
		rd(TCU_OFS_TIME, d);
		repeat (14) u_tcu_partner.toggle_line(0, 8);
		repeat (12) @(posedge clk);
		chk("rearm", 16'(cap_seen - n), 16'h0002);
	endtask

	task automatic t_compare();
		int s;
		int c;
		logic [15:0] cmd [3] = '{16'h0061, 16'h0048, 16'h004F};
		wr(TCU_OFS_IO_CONTROL_SECOND, 16'h0010);
		repeat (3) @(posedge clk);
		chk("oe", {14'h0, out_oe}, 16'h0001);
		foreach (cmd[i])
		begin
			wr(TCU_OFS_STAT, cmd[i]);
			wr(TCU_OFS_TIME, 16'(i + 3));
			repeat (10) @(posedge clk);
		end
		rdchk("hold", TCU_OFS_IO_STATUS_FIRST, 16'h0080, 16'h0000);
		s = swt_seen;
		c = conv_seen;
		repeat (2) u_tcu_partner.toggle_t2(8);
		repeat (16) @(posedge clk);
		chk("early", {15'h0, out_line[1]}, 16'h0000);
		u_tcu_partner.toggle_t2(24);
		chk("set", {15'h0, out_line[1]}, 16'h0001);
		u_tcu_partner.toggle_t2(24);
		chk("swt", 16'(swt_seen - s), 16'h0001);
		rdchk("flag", TCU_OFS_IO_STATUS_SECOND, 16'h000F, 16'h0001);
		rdchk("clear", TCU_OFS_IO_STATUS_SECOND, 16'h000F, 16'h0000);
		u_tcu_partner.toggle_t2(24);
		chk("conv", 16'(conv_seen - c), 16'h0001);
	endtask

	task automatic t_modes();
		int n;
		logic [15:0] d;
		repeat (7) rd(TCU_OFS_TIME, d);
		wr(TCU_OFS_IO_CONTROL_SECOND, 16'h0000);
		wr(TCU_OFS_MODE, 16'h0054);
		n = cap_seen;
		repeat (14) u_tcu_partner.toggle_line(0, 8);
		chk("eighth7", 16'(cap_seen - n), 16'h0000);
		repeat (2) u_tcu_partner.toggle_line(0, 8);
		repeat (4) @(posedge clk);
		chk("eighth8", 16'(cap_seen - n), 16'h0001);
		rd(TCU_OFS_TIME, d);
		wr(TCU_OFS_MODE, 16'h0056);
		repeat (2) u_tcu_partner.toggle_line(0, 8);
		repeat (4) @(posedge clk);
		chk("falling", 16'(cap_seen - n), 16'h0002);
		rd(TCU_OFS_TIME, d);
		wr(TCU_OFS_MODE, 16'h0057);
		u_tcu_partner.toggle_line(0, 8);
		rd(TCU_OFS_TIME, d);
		u_tcu_partner.toggle_line(0, 8);
		repeat (4) @(posedge clk);
		chk("both", 16'(cap_seen - n), 16'h0004);
		rd(TCU_OFS_TIME, d);
	endtask

	task automatic t_full();
		wr(TCU_OFS_STAT, 16'h0000);
		repeat (8)
		begin
			wr(TCU_OFS_TIME, 16'h7000);
			repeat (8) @(posedge clk);
		end
		rdchk("file_full", TCU_OFS_IO_STATUS_FIRST, 16'h00C0, 16'h0040);
		wr(TCU_OFS_TIME, 16'h7000);
		rdchk("hold_busy", TCU_OFS_IO_STATUS_FIRST, 16'h00C0, 16'h00C0);
	endtask

	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		bus = '0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_capture();
		t_overflow();
		t_modes();
		t_compare();
		t_full();
		conclude();
	end
endmodule // tb
